// file: hdl/pcm_pkg.sv
// constants for the pll calibration and monitor control slice
// Notes on behaviour
// R1: lock-detect disable bit clear means detection runs
// R2: calibration clock is reference divided 2/4/8/16
// R3: host picks divider to suit detector rate
// R4: calibration starts on active bit rising edge
// R5: host writes 0, transfers, writes 1, transfers
// R6: host keeps vco divider still while calibrating
// R7: alignment pin: none, async or sync counter reset
// R8: reference and feedback delay fields, default zero
// R9: status output divided by four when enabled
// R10: reference valid above 1.02 MHz or 6 kHz
// R11: threshold bit affects reference monitors only
`default_nettype none

package pcm_pkg;

    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [9:0] PCM_OFS_LOCK_CAL    = 10'h018;
    localparam logic [9:0] PCM_OFS_ALIGN_DELAY = 10'h019;
    localparam logic [9:0] PCM_OFS_STAT_THRESH = 10'h01A;
    localparam logic [7:0] PCM_RST_LOCK_CAL    = 8'h06;
    localparam logic [7:0] PCM_RST_ALIGN_DELAY = 8'h00;
    localparam logic [7:0] PCM_RST_STAT_THRESH = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PCM_BIT_LD_DISABLE  = 3;
    localparam int PCM_BIT_CAL_DIV_LO  = 1;
    localparam int PCM_BIT_CAL_NOW     = 0;
    localparam int PCM_BIT_ALIGN_LO    = 6;
    localparam int PCM_BIT_REF_DLY_LO  = 3;
    localparam int PCM_BIT_FB_DLY_LO   = 0;
    localparam int PCM_BIT_STAT_DIV    = 7;
    localparam int PCM_BIT_REF_THRESH  = 6;

    // alignment pin reaction codes
    typedef enum logic [1:0] {
        PCM_ALIGN_NONE  = 2'b00,
        PCM_ALIGN_ASYNC = 2'b01,
        PCM_ALIGN_SYNC  = 2'b10,
        PCM_ALIGN_NONE2 = 2'b11
    } pcm_align_t;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PCM_CLK_HZ          = 10000000;
    localparam int PCM_REF_HI_HZ       = 1020000;
    localparam int PCM_REF_LO_HZ       = 6000;
    // longest edge spacing still counted valid, rounded down
    localparam logic [10:0] PCM_REF_HI_CYC = 11'(PCM_CLK_HZ / PCM_REF_HI_HZ);
    localparam logic [10:0] PCM_REF_LO_CYC = 11'(PCM_CLK_HZ / PCM_REF_LO_HZ);

endpackage : pcm_pkg

`default_nettype wire

// file: hdl/pcm_ctrl.sv
// pll calibration, alignment, delay, status divider and reference monitor control
`default_nettype none

module pcm_ctrl (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        wr_en_i,
    input  wire logic [9:0]  wr_addr_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        update_i,
    input  wire logic [9:0]  rd_addr_i,
    output logic      [7:0]  rd_data_o,
    input  wire logic        pll_ref_i,
    input  wire logic        first_reference_input_i,
    input  wire logic        second_reference_input_i,
    input  wire logic        align_pin_i,
    input  wire logic        status_sig_i,
    output logic             lock_detect_en_o,
    output logic             cal_clk_o,
    output logic             cal_start_o,
    output logic             counter_async_rst_o,
    output logic             counter_sync_rst_o,
    output logic      [2:0]  ref_delay_o,
    output logic      [2:0]  fb_delay_o,
    output logic             status_o,
    output logic      [1:0]  ref_valid_o
);
    import pcm_pkg::*;

    // half period of the calibration clock in reference edges
    function automatic logic [3:0] pcm_half_count(input logic [1:0] code);
        pcm_half_count = 4'(4'h1 << code);
    endfunction : pcm_half_count

    // ************************************************************
    // staged and active registers
    // ************************************************************
    logic [7:0] stg_lock_r, stg_align_r, stg_stat_r;
    logic [7:0] act_lock_r, act_align_r, act_stat_r;
    logic       cal_prev_r;

    // host writes land in the staged copy only
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stg_lock_r  <= PCM_RST_LOCK_CAL;
            stg_align_r <= PCM_RST_ALIGN_DELAY;
            stg_stat_r  <= PCM_RST_STAT_THRESH;
        end else if (wr_en_i) begin
            if (wr_addr_i == PCM_OFS_LOCK_CAL)    stg_lock_r  <= wr_data_i;
            if (wr_addr_i == PCM_OFS_ALIGN_DELAY) stg_align_r <= wr_data_i;
            if (wr_addr_i == PCM_OFS_STAT_THRESH) stg_stat_r  <= wr_data_i;
        end
    end

    // transfer strobe commits all staged values at once
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            act_lock_r  <= PCM_RST_LOCK_CAL;
            act_align_r <= PCM_RST_ALIGN_DELAY;
            act_stat_r  <= PCM_RST_STAT_THRESH;
        end else if (update_i) begin
            act_lock_r  <= stg_lock_r;
            act_align_r <= stg_align_r;
            act_stat_r  <= stg_stat_r;
        end
    end

    // reads return the active copy; unmapped addresses read zero
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 8'h00;
        end else begin
            case (rd_addr_i)
                PCM_OFS_LOCK_CAL:    rd_data_o <= act_lock_r;
                PCM_OFS_ALIGN_DELAY: rd_data_o <= act_align_r;
                PCM_OFS_STAT_THRESH: rd_data_o <= act_stat_r;
                default:             rd_data_o <= 8'h00;
            endcase
        end
    end

    // ************************************************************
    // field outputs
    // ************************************************************
    // R1: lock detect follows disable bit, registered with the commit so the pin
    // comes straight from a flop and moves on the same edge as the active copy
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_detect_en_o <= ~PCM_RST_LOCK_CAL[PCM_BIT_LD_DISABLE];
        end else if (update_i) begin
            lock_detect_en_o <= ~stg_lock_r[PCM_BIT_LD_DISABLE];
        end
    end
    // R8: delay fields straight from active register
    assign ref_delay_o = act_align_r[PCM_BIT_REF_DLY_LO +: 3];
    assign fb_delay_o  = act_align_r[PCM_BIT_FB_DLY_LO +: 3];

    // R4: start pulse on zero-to-one of active bit
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cal_prev_r  <= 1'b0;
            cal_start_o <= 1'b0;
        end else begin
            cal_prev_r  <= act_lock_r[PCM_BIT_CAL_NOW];
            cal_start_o <= act_lock_r[PCM_BIT_CAL_NOW] & ~cal_prev_r;
        end
    end

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    // bit order: pll_ref, first_reference_input, second_reference_input, align, status
    logic [4:0] sync1_r, sync2_r, prev_r, rise;

    // the first stage feeds only the second stage
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            prev_r  <= 5'h00;
        end else begin
            sync1_r <= {status_sig_i, align_pin_i, second_reference_input_i,
                        first_reference_input_i, pll_ref_i};
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end
    assign rise = sync2_r & ~prev_r;

    // ************************************************************
    // calibration clock divider
    // ************************************************************
    // sampling limits the usable reference to below half of clock_i
    logic [3:0] cal_cnt_r;

    // R2: toggle after half the selected ratio of edges
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cal_cnt_r <= 4'h0;
            cal_clk_o <= 1'b0;
        end else if (rise[0]) begin
            if (cal_cnt_r + 4'h1 >= pcm_half_count(act_lock_r[PCM_BIT_CAL_DIV_LO +: 2])) begin
                cal_cnt_r <= 4'h0;
                cal_clk_o <= ~cal_clk_o;
            end else begin
                cal_cnt_r <= cal_cnt_r + 4'h1;
            end
        end
    end

    // ************************************************************
    // alignment pin counter reset
    // ************************************************************
    pcm_align_t align_mode;
    assign align_mode = pcm_align_t'(act_align_r[PCM_BIT_ALIGN_LO +: 2]);

    // R7: async level while pin high, sync one-cycle pulse on its edge
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            counter_async_rst_o <= 1'b0;
            counter_sync_rst_o  <= 1'b0;
        end else begin
            case (align_mode)
                PCM_ALIGN_ASYNC: begin
                    counter_async_rst_o <= sync2_r[3];
                    counter_sync_rst_o  <= 1'b0;
                end
                PCM_ALIGN_SYNC: begin
                    counter_async_rst_o <= 1'b0;
                    counter_sync_rst_o  <= rise[3];
                end
                default: begin
                    counter_async_rst_o <= 1'b0;
                    counter_sync_rst_o  <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // status output divider
    // ************************************************************
    logic       stat_half_r;
    logic       stat_div_r;

    // R9: divide by four toggles every second rising edge
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stat_half_r <= 1'b0;
            stat_div_r  <= 1'b0;
            status_o    <= 1'b0;
        end else begin
            if (rise[4]) begin
                stat_half_r <= ~stat_half_r;
                if (stat_half_r) stat_div_r <= ~stat_div_r;
            end
            status_o <= act_stat_r[PCM_BIT_STAT_DIV] ? stat_div_r : sync2_r[4];
        end
    end

    // ************************************************************
    // reference frequency monitors
    // ************************************************************
    logic [10:0] mon_cnt_r [2];
    logic [10:0] mon_limit;

    // R11: the threshold bit reaches these two monitors and no other
    // R10: limit in cycles per selected frequency
    assign mon_limit = act_stat_r[PCM_BIT_REF_THRESH] ? PCM_REF_LO_CYC : PCM_REF_HI_CYC;

    // R10: valid while edges come no further apart than the limit
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mon_cnt_r[0] <= 11'h000;
            mon_cnt_r[1] <= 11'h000;
            ref_valid_o  <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rise[i + 1]) begin
                    mon_cnt_r[i]   <= 11'h000;
                    ref_valid_o[i] <= (mon_cnt_r[i] < mon_limit);
                end else if (mon_cnt_r[i] >= mon_limit) begin
                    ref_valid_o[i] <= 1'b0; // spacing exceeded: stalled input
                end else begin
                    mon_cnt_r[i] <= mon_cnt_r[i] + 11'h001;
                end
            end
        end
    end

endmodule : pcm_ctrl

`default_nettype wire

// file: sim/pcm_ctrl_asserts.sv
// port checker for the pll control slice
`default_nettype none
module pcm_ctrl_asserts
    import pcm_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic       update_i,
    input wire logic [9:0] rd_addr_i,
    input wire logic [7:0] rd_data_o,
    input wire logic       lock_detect_en_o,
    input wire logic       cal_start_o,
    input wire logic       counter_async_rst_o,
    input wire logic       counter_sync_rst_o,
    input wire logic [2:0] ref_delay_o,
    input wire logic [2:0] fb_delay_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // reads are checked two edges clear of a commit, so field outputs have settled
    a_field_hold: assert property (!update_i |=> $stable({ref_delay_o, fb_delay_o}))
        else $error("delay moved without commit");
    a_ld_read: assert property (rd_addr_i == PCM_OFS_LOCK_CAL && !update_i
        && !$past(update_i) |=> rd_data_o[3] == !lock_detect_en_o) else $error("lock bit");
    a_dly_read: assert property (rd_addr_i == PCM_OFS_ALIGN_DELAY && !update_i
        && !$past(update_i) |=> rd_data_o[5:0] == {ref_delay_o, fb_delay_o})
        else $error("delay readback");
    a_unmapped_zero: assert property (!(rd_addr_i inside {10'h018, 10'h019, 10'h01A})
        |=> rd_data_o == 8'h00) else $error("unmapped read");
    a_cal_pulse: assert property (cal_start_o |=> !cal_start_o)
        else $error("cal start too long");
    a_cal_cause: assert property ($rose(cal_start_o) |-> $past(update_i, 2))
        else $error("cal start without commit");
    a_sync_pulse: assert property (counter_sync_rst_o |=> !counter_sync_rst_o)
        else $error("sync reset too long");
    a_reset_excl: assert property (!(counter_async_rst_o && counter_sync_rst_o))
        else $error("both counter resets");
endmodule : pcm_ctrl_asserts
`default_nettype wire

// file: sim/pcm_host.sv
// host model that stages and commits register bytes
`default_nettype none
module pcm_host
    import pcm_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic [7:0] rd_data_i,
    output var  logic       wr_en_o = 1'b0,
    output var  logic [9:0] wr_addr_o = 10'h000,
    output var  logic [7:0] wr_data_o = 8'h00,
    output var  logic       update_o = 1'b0,
    output var  logic [9:0] rd_addr_o = 10'h3FF
);
    timeunit 1ns;
    timeprecision 1ns;
    // released bus shows inverted values so stale data cannot pass
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_en_o <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        @(posedge clock_i);
        wr_en_o <= 1'b0;
        wr_addr_o <= ~a;
        wr_data_o <= ~d;
    endtask : wr
    // one-cycle commit of staged bytes
    task automatic upd();
        @(posedge clock_i);
        update_o <= 1'b1;
        @(posedge clock_i);
        update_o <= 1'b0;
    endtask : upd
    // read data settles one edge after the address
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clock_i);
        rd_addr_o <= a;
        @(negedge clock_i);
        @(negedge clock_i);
        d = rd_data_i;
    endtask : rd
    task automatic cal(input logic [7:0] d);
        wr(PCM_OFS_LOCK_CAL, d & 8'hFE);
        upd();
        wr(PCM_OFS_LOCK_CAL, d | 8'h01);
        upd();
    endtask : cal
endmodule : pcm_host
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the pll control slice
`default_nettype none
module testbench;
    import pcm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_i = 1'b0, rst_b_i = 1'b0, align_pin_i = 1'b0;
    logic wr_en_i, update_i, cal_clk_o, cal_start_o, lock_detect_en_o, status_o;
    logic counter_async_rst_o, counter_sync_rst_o;
    logic [9:0] wr_addr_i, rd_addr_i;
    logic [7:0] wr_data_i, rd_data_o, got, tick = 8'h00;
    logic [2:0] ref_delay_o, fb_delay_o;
    logic [1:0] ref_valid_o;
    int err_total = 0, checked = 0, n_cal = 0, n_syn = 0;
    pcm_ctrl i_dut (.clock_i, .rst_b_i, .wr_en_i, .wr_addr_i, .wr_data_i, .update_i,
        .rd_addr_i, .rd_data_o, .pll_ref_i(tick[2]), .first_reference_input_i(tick[2]),
        .second_reference_input_i(tick[5]), .align_pin_i, .status_sig_i(tick[1]),
        .lock_detect_en_o, .cal_clk_o, .cal_start_o, .counter_async_rst_o,
        .counter_sync_rst_o, .ref_delay_o, .fb_delay_o, .status_o, .ref_valid_o);
    pcm_host i_host (.clock_i, .rd_data_i(rd_data_o), .wr_en_o(wr_en_i), .wr_addr_o(wr_addr_i),
        .wr_data_o(wr_data_i), .update_o(update_i), .rd_addr_o(rd_addr_i));
    initial forever #50 clock_i = ~clock_i;
    // reference and status pins run free at fixed ratios, the align pin is driven by t_align; pulse outputs are tallied
    always @(posedge clock_i) begin
        tick <= tick + 8'h01;
        n_cal <= n_cal + int'(cal_start_o);
        n_syn <= n_syn + int'(counter_sync_rst_o);
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    // cycles between output changes; the status path can switch source mid-phase
    // one edge after a commit, so only the fourth span is sure to be whole
    task automatic gap(input bit s, output int k);
        logic v;
        for (int i = 0; i < 4; i++) begin
            v = s ? status_o : cal_clk_o;
            k = 0;
            while ((s ? status_o : cal_clk_o) === v && k < 300) begin
                @(negedge clock_i);
                k++;
            end
        end
    endtask : gap
    task automatic t_regs();
        logic [9:0] a [4] = '{PCM_OFS_LOCK_CAL, PCM_OFS_ALIGN_DELAY, PCM_OFS_STAT_THRESH, 10'h0FF};
        logic [7:0] e [4] = '{8'h06, 8'h00, 8'h00, 8'h00};
        foreach (a[i]) begin
            i_host.rd(a[i], got);
            chk(got, e[i]);
        end
        chk({7'h00, lock_detect_en_o}, 8'h01);
    endtask : t_regs
    task automatic t_align();
        int n;
        i_host.wr(PCM_OFS_ALIGN_DELAY, 8'h6B);
        chk({2'b00, ref_delay_o, fb_delay_o}, 8'h00);
        for (int c = 0; c < 4; c++) begin
            i_host.wr(PCM_OFS_ALIGN_DELAY, {c[1:0], 6'h2B});
            i_host.upd();
            align_pin_i <= 1'b0;
            repeat (6) @(posedge clock_i);
            n = n_syn;
            align_pin_i <= 1'b1;
            repeat (8) @(posedge clock_i);
            chk({2'b00, ref_delay_o, fb_delay_o}, 8'h2B);
            chk(8'(n_syn - n), {7'h00, c == 2});
            chk({7'h00, counter_async_rst_o}, {7'h00, c == 1});
        end
        align_pin_i <= 1'b0;
        i_host.rd(PCM_OFS_ALIGN_DELAY, got);
        chk(got, 8'hEB);
    endtask : t_align
    task automatic t_cal();
        int n, k;
        n = n_cal;
        i_host.cal(8'h06);
        repeat (4) @(posedge clock_i);
        i_host.upd();
        repeat (4) @(posedge clock_i);
        chk(8'(n_cal - n), 8'h01);
        // reference at 1.25 MHz suits every code
        for (int c = 0; c < 4; c++) begin
            i_host.wr(PCM_OFS_LOCK_CAL, {4'h0, 1'b1, c[1:0], 1'b0});
            i_host.upd();
            gap(1'b0, k);
            chk(8'(k), 8'(8 << c));
        end
        chk({7'h00, lock_detect_en_o}, 8'h00);
        i_host.rd(PCM_OFS_LOCK_CAL, got);
        chk(got, 8'h0E);
        chk(8'(n_cal - n), 8'h01);
    endtask : t_cal
    task automatic t_stat();
        int k;
        for (int b = 0; b < 2; b++) begin
            i_host.wr(PCM_OFS_STAT_THRESH, {b[0], b[0], 6'h00});
            i_host.upd();
            gap(1'b1, k);
            chk(8'(k), b ? 8'h08 : 8'h02);
            repeat (150) @(posedge clock_i);
            chk({6'h00, ref_valid_o}, b ? 8'h03 : 8'h01);
        end
    endtask : t_stat
    task automatic wrap_up();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (12) @(posedge clock_i);
        rst_b_i <= 1'b1;
        t_regs();
        t_align();
        t_cal();
        t_stat();
        wrap_up();
    end
    // about twenty times the expected run
    initial begin
        #2000000;
        err_total++;
        wrap_up();
    end
endmodule : testbench
bind pcm_ctrl pcm_ctrl_asserts i_chk (.clock_i, .rst_b_i, .update_i, .rd_addr_i, .rd_data_o,
    .lock_detect_en_o, .cal_start_o, .counter_async_rst_o, .counter_sync_rst_o,
    .ref_delay_o, .fb_delay_o);
`default_nettype wire
